// ==== hifrc_defines.vh ====
/*
  Register offsets, field positions, reset values and encodings for the host
  interrupt mask, FIFO threshold and receive read configuration block.
  Assumes inclusion by bare name from the design file; definitions only.
*/
`ifndef HIFRC_DEFINES_VH
`define HIFRC_DEFINES_VH

`define HIFRC_OFF_INT_MASK   12'h05c
`define HIFRC_OFF_STATUS     12'h058
`define HIFRC_OFF_BYTE_ORDER 12'h064
`define HIFRC_OFF_FIFO_LVL   12'h068
`define HIFRC_OFF_RX_CFG     12'h06c
`define HIFRC_OFF_RX_STAT    12'h080
`define HIFRC_ADDR_W         12

`define HIFRC_MASK_RW        32'h83bfefff
`define HIFRC_MASK_GPIO      32'h00000007
`define HIFRC_BYTE_PATTERN   32'h87654321
`define HIFRC_FIFO_LVL_RST   32'h48000000
`define HIFRC_RX_CFG_RST     32'h00000000
`define HIFRC_RX_CFG_RW      32'hcfff1f00

`define HIFRC_BIT_RXDMA      20
`define HIFRC_BIT_TXSPACE    9
`define HIFRC_BIT_TXSLVL     7
`define HIFRC_BIT_RXDLVL     5
`define HIFRC_BIT_RXSLVL     3

`define HIFRC_TXSPACE_HI     31
`define HIFRC_TXSPACE_LO     24
`define HIFRC_TXSLVL_HI      23
`define HIFRC_TXSLVL_LO      16
`define HIFRC_RXSPACE_HI     15
`define HIFRC_RXSPACE_LO     8
`define HIFRC_RXSLVL_HI      7
`define HIFRC_RXSLVL_LO      0

`define HIFRC_ALIGN_HI       31
`define HIFRC_ALIGN_LO       30
`define HIFRC_CNT_HI         27
`define HIFRC_CNT_LO         16
`define HIFRC_DUMP_BIT       15
`define HIFRC_OFF_HI         12
`define HIFRC_OFF_LO         8
`define HIFRC_OFF_DW_LO      10

`define HIFRC_ALIGN_4        2'h0
`define HIFRC_ALIGN_16       2'h1
`define HIFRC_ALIGN_32       2'h2
`define HIFRC_PAD_MASK_4     2'h0
`define HIFRC_PAD_MASK_16    2'h3
`define HIFRC_PAD_MASK_32    3'h7

`endif

// ==== hifrc_regs.v ====
/*
  APB register bank: interrupt mask and status gating onto one host
  interrupt, byte-order probe with wake on write, FIFO threshold events,
  receive read configuration (end padding, DWORD countdown, flush, offset).
  Assumes FIFO levels and event pulses come from the FIFO controllers on clk,
  and that the receive reader reports each DWORD it pops and each packet end.
*/
//
// What this block does
// - Mask bit lets its source drive interrupt
// - Status latches events regardless of mask
// - Mask bits 31,25,24,23, read/write, reset zero
// - Mask bits 21 to 16, read/write, reset zero
// - Mask bits 15-13, 11-7 per source
// - Mask bits 6-3 and pin events 2-0
// - Byte-order probe always reads fixed pattern
// - Any write to probe wakes device
// - TX space event above level, reset 48h
// - TX status event above level, reset 00h
// - RX data event when free space below
// - RX status event above occupancy level
// - Pad buffer end to 4/16/32 byte boundary
// - DWORD countdown decrements, raises RX DMA event
// - New count write replaces running count
// - Flush bit resets RX pointers, self-clears
// - Offset inserts 0-31 bytes before packet data
// - Upper offset bits take effect next DWORD
// - Status bit 20 set on countdown, write-one clears
`timescale 1ns/10ps
`include "hifrc_defines.vh"

module hifrc_regs (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata,
  output wire        pslverr,
  input  wire [31:0] event_pulses,
  input  wire [7:0]  tx_data_free_blocks,
  input  wire [7:0]  tx_status_used_dwords,
  input  wire [7:0]  rx_data_free_blocks,
  input  wire [7:0]  rx_status_used_dwords,
  input  wire        rx_dword_pop,
  input  wire        rx_packet_end,
  output wire        host_irq,
  output reg         wake_pulse,
  output reg         rx_fifo_flush,
  output reg  [2:0]  rx_pad_dwords,
  output reg         rx_pad_valid,
  output reg  [4:0]  rx_start_byte_offset,
  output reg  [11:0] rx_dword_countdown
);

  reg  [31:0] interrupt_mask_q;
  reg  [31:0] interrupt_status_q;
  reg  [31:0] fifo_threshold_levels_q;
  reg  [1:0]  end_align_q;
  reg  [2:0]  dword_phase_q;
  reg         cnt_armed_q;
  reg  [4:0]  offset_pend_q;
  wire        acc;
  wire        wr;
  wire        rd;
  wire [31:0] lvl_events;
  wire [31:0] w1c;
  wire        cnt_done;
  reg  [2:0]  pad_mask;
  reg         mapped;
  reg         ready_q;
  wire [31:0] interrupt_status_d;
  wire [2:0]  pad_fill;

  // One wait state: read data is registered, so pready rises with it a cycle after penable
  assign acc     = psel & penable & ready_q;
  assign wr      = acc & pwrite;
  assign rd      = psel & penable & ~ready_q & ~pwrite;
  assign pready  = ready_q;
  assign pslverr = psel & penable & ~mapped;

  // Ready rises in the second access cycle and drops with the completing edge
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ready_q <= 1'b0;
    end else begin
      ready_q <= psel & penable & ~ready_q;
    end
  end

  // Address decode; unmapped addresses read zero and answer with an error
  always @* begin
    mapped = 1'b1;
    case (paddr)
      `HIFRC_OFF_INT_MASK:   mapped = 1'b1;
      `HIFRC_OFF_STATUS:     mapped = 1'b1;
      `HIFRC_OFF_BYTE_ORDER: mapped = 1'b1;
      `HIFRC_OFF_FIFO_LVL:   mapped = 1'b1;
      `HIFRC_OFF_RX_CFG:     mapped = 1'b1;
      default:               mapped = 1'b0;
    endcase
  end

  // Mask register: reserved bits never store, so they read zero
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_mask_q <= 32'h00000000;
    end else if (wr && paddr == `HIFRC_OFF_INT_MASK) begin
      interrupt_mask_q <= pwdata & `HIFRC_MASK_RW;
    end
  end

  // Threshold comparators; level events stay high for as long as the condition holds
  assign lvl_events[`HIFRC_BIT_TXSPACE] = tx_data_free_blocks >
    fifo_threshold_levels_q[`HIFRC_TXSPACE_HI:`HIFRC_TXSPACE_LO];
  assign lvl_events[`HIFRC_BIT_TXSLVL] = tx_status_used_dwords >
    fifo_threshold_levels_q[`HIFRC_TXSLVL_HI:`HIFRC_TXSLVL_LO];
  assign lvl_events[`HIFRC_BIT_RXDLVL] = rx_data_free_blocks <
    fifo_threshold_levels_q[`HIFRC_RXSPACE_HI:`HIFRC_RXSPACE_LO];
  assign lvl_events[`HIFRC_BIT_RXSLVL] = rx_status_used_dwords >
    fifo_threshold_levels_q[`HIFRC_RXSLVL_HI:`HIFRC_RXSLVL_LO];
  assign lvl_events[`HIFRC_BIT_RXDMA] = cnt_done;
  assign lvl_events[31:21] = 11'h000;
  assign lvl_events[19:10] = 10'h000;
  assign lvl_events[8]     = 1'b0;
  assign lvl_events[6]     = 1'b0;
  assign lvl_events[4]     = 1'b0;
  assign lvl_events[2:0]   = 3'h0;

  assign w1c = (wr && paddr == `HIFRC_OFF_STATUS) ? pwdata : 32'h00000000;

  // Sticky status per bit; a new event wins over a same-cycle clear
  genvar gi;
  generate
    for (gi = 0; gi < 32; gi = gi + 1) begin : g_sts
      if (((`HIFRC_MASK_RW >> gi) & 32'h1) != 32'h0) begin : g_live
        assign interrupt_status_d[gi] = event_pulses[gi] | lvl_events[gi] |
                                        (interrupt_status_q[gi] & ~w1c[gi]);
      end else begin : g_rsvd
        assign interrupt_status_d[gi] = 1'b0;
      end
    end
  endgenerate

  // One register for the whole status word keeps a single driver per bit
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      interrupt_status_q <= 32'h00000000;
    end else begin
      interrupt_status_q <= interrupt_status_d;
    end
  end

  assign host_irq = |(interrupt_status_q & interrupt_mask_q);

  // Wake strobe on any write to the probe, data ignored
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      wake_pulse <= 1'b0;
    end else begin
      wake_pulse <= wr && paddr == `HIFRC_OFF_BYTE_ORDER;
    end
  end

  // Threshold register
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fifo_threshold_levels_q <= `HIFRC_FIFO_LVL_RST;
    end else if (wr && paddr == `HIFRC_OFF_FIFO_LVL) begin
      fifo_threshold_levels_q <= pwdata;
    end
  end

  // A same-cycle count write replaces the run, so it suppresses the event
  assign cnt_done = cnt_armed_q && rx_dword_pop && !(wr && paddr == `HIFRC_OFF_RX_CFG) &&
                    rx_dword_countdown == 12'h001;

  // Receive config: countdown, flush strobe, alignment and offset
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      end_align_q          <= `HIFRC_ALIGN_4;
      rx_dword_countdown   <= 12'h000;
      cnt_armed_q          <= 1'b0;
      rx_fifo_flush        <= 1'b0;
      rx_start_byte_offset <= 5'h00;
      offset_pend_q        <= 5'h00;
    end else begin
      rx_fifo_flush <= 1'b0;
      if (wr && paddr == `HIFRC_OFF_RX_CFG) begin
        end_align_q        <= pwdata[`HIFRC_ALIGN_HI:`HIFRC_ALIGN_LO];
        rx_dword_countdown <= pwdata[`HIFRC_CNT_HI:`HIFRC_CNT_LO];
        cnt_armed_q        <= |pwdata[`HIFRC_CNT_HI:`HIFRC_CNT_LO];
        rx_fifo_flush      <= pwdata[`HIFRC_DUMP_BIT];
        offset_pend_q      <= pwdata[`HIFRC_OFF_HI:`HIFRC_OFF_LO];
        // Low offset bits are only safe with the receiver idle, so apply now
        rx_start_byte_offset[1:0] <= pwdata[`HIFRC_OFF_LO+1:`HIFRC_OFF_LO];
      end else begin
        if (rx_dword_pop && cnt_armed_q) begin
          rx_dword_countdown <= rx_dword_countdown - 12'h001;
          if (rx_dword_countdown == 12'h001) begin
            cnt_armed_q <= 1'b0;
          end
        end
        if (rx_dword_pop) begin
          rx_start_byte_offset[4:2] <= offset_pend_q[4:2];
        end
      end
    end
  end

  // Padding mask for the chosen boundary, in DWORDs
  always @* begin
    case (end_align_q)
      `HIFRC_ALIGN_16: pad_mask = {1'b0, `HIFRC_PAD_MASK_16};
      `HIFRC_ALIGN_32: pad_mask = `HIFRC_PAD_MASK_32;
      default:         pad_mask = {1'b0, `HIFRC_PAD_MASK_4};
    endcase
  end

  // DWORDs still missing to the boundary, counting the word popped now
  assign pad_fill = (3'h0 - (dword_phase_q + {2'b00, rx_dword_pop})) & pad_mask;

  // Track DWORD phase within the buffer; report filler count at packet end
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dword_phase_q <= 3'h0;
      rx_pad_dwords <= 3'h0;
      rx_pad_valid  <= 1'b0;
    end else begin
      rx_pad_valid <= 1'b0;
      if (rx_fifo_flush) begin
        dword_phase_q <= 3'h0;
      end else if (rx_packet_end) begin
        // Filler count to next boundary; host drops these DWORDs
        rx_pad_dwords <= pad_fill;
        rx_pad_valid  <= 1'b1;
        dword_phase_q <= 3'h0;
      end else if (rx_dword_pop) begin
        dword_phase_q <= dword_phase_q + 3'h1;
      end
    end
  end

  // Read mux, registered data output
  always @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prdata <= 32'h00000000;
    end else if (rd) begin
      case (paddr)
        `HIFRC_OFF_INT_MASK:   prdata <= interrupt_mask_q;
        `HIFRC_OFF_STATUS:     prdata <= interrupt_status_q;
        `HIFRC_OFF_BYTE_ORDER: prdata <= `HIFRC_BYTE_PATTERN;
        `HIFRC_OFF_FIFO_LVL:   prdata <= fifo_threshold_levels_q;
        `HIFRC_OFF_RX_CFG:     prdata <= {end_align_q, 2'b00, rx_dword_countdown,
                                          1'b0, 2'b00, offset_pend_q, 8'h00};
        default:               prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ==== hifrc_regs_properties.sv ====
/* Concurrent checks on the APB and receive control ports of the register bank.
   Assumes one clock domain; attached to every bank instance by the bind below. */
`timescale 1ns/10ps
module hifrc_regs_properties (
  input wire        clk,
  input wire        sys_rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire [31:0] prdata,
  input wire        pslverr,
  input wire        rx_dword_pop,
  input wire        wake_pulse,
  input wire        rx_fifo_flush,
  input wire [11:0] rx_dword_countdown
);
  // Completed transfer and a completed write to the receive config word
  wire acc = psel && penable && pready;
  wire cfg_wr = acc && pwrite && paddr == 12'h06c;
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  err_map_a: assert property (psel && penable |-> pslverr ==
    !(paddr inside {12'h058, 12'h05c, 12'h064, 12'h068, 12'h06c}))
    else $error("error response wrong for this address");
  wake_write_a: assert property (acc && pwrite && paddr == 12'h064 |=> wake_pulse)
    else $error("probe write gave no wake");
  wake_cause_a: assert property (wake_pulse |-> $past(acc && pwrite && paddr == 12'h064))
    else $error("wake without probe write");
  flush_set_a: assert property (cfg_wr && pwdata[15] |=> rx_fifo_flush)
    else $error("flush write gave no flush");
  flush_cause_a: assert property (rx_fifo_flush |-> $past(cfg_wr && pwdata[15]))
    else $error("flush without cause");
  count_load_a: assert property (cfg_wr |=> rx_dword_countdown == $past(pwdata[27:16]))
    else $error("count write not loaded");
  count_step_a: assert property (rx_dword_pop && rx_dword_countdown != 12'h000 && !cfg_wr
    |=> rx_dword_countdown == $past(rx_dword_countdown) - 12'h001)
    else $error("count did not step");
  probe_read_a: assert property (acc && !pwrite && paddr == 12'h064 |-> prdata == 32'h87654321)
    else $error("probe read wrong");
endmodule
bind hifrc_regs hifrc_regs_properties hifrc_regs_properties_inst (.clk(clk), .sys_rst(sys_rst),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .prdata(prdata), .pslverr(pslverr), .rx_dword_pop(rx_dword_pop),
  .wake_pulse(wake_pulse), .rx_fifo_flush(rx_fifo_flush),
  .rx_dword_countdown(rx_dword_countdown));

// ==== hifrc_host.sv ====
/* Host CPU model: APB master doing one word transfer per call.
   Assumes the slave answers with pready; a missing answer raises hung. */
`timescale 1ns/10ps
module hifrc_host (
  input  wire        clk,
  input  wire        pready,
  input  wire [31:0] prdata,
  output reg         psel,
  output reg         penable,
  output reg         pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata,
  output reg         hung
);
  initial {psel, penable, pwrite, paddr, pwdata, hung} = 48'h0;
  // Request held until pready; read data taken at that same edge
  // Alignment and low offset bits are rewritten only between packets
  task xfer(input w, input [11:0] a, input [31:0] wd, output [31:0] rd);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1 && n < 16);
      rd = prdata; // Filler words never reach packet data here
      hung <= (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
endmodule

// ==== hifrc_testbench.sv ====
/* Self-checking bench for the register bank, driven through the host model.
   Assumes the bank answers every transfer and levels sit idle at zero. */
`timescale 1ns/10ps
`include "hifrc_defines.vh"
module testbench;
  reg clk = 1'b0;
  reg sys_rst = 1'b1;
  reg [31:0] ev = 32'h0;
  reg [7:0] txf = 8'h0, txs = 8'h0, rxf = 8'h0, rxs = 8'h0;
  reg pop = 1'b0;
  reg pend = 1'b0;
  reg [31:0] seed = 32'h3a313108, d, r;
  wire psel, penable, pwrite, pready, hung, host_irq;
  wire [11:0] paddr, cnt;
  wire [31:0] pwdata, prdata;
  wire [4:0] offs;
  wire wake, flush, padv;
  wire [2:0] pad;
  integer err_count = 0, n_tests = 0, i;
  int bl [6] = '{31, 25, 23, 15, 11, 1};
  always #10 clk = ~clk;
  function [31:0] rnd;
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    rnd = seed;
  endfunction
  // Filler DWORDs after n data DWORDs for a 4, 16 or 32 byte boundary
  function [2:0] pad_exp(input [1:0] a, input [3:0] n);
    integer dw;
    begin
      dw = (a == 2'd0) ? 1 : (a == 2'd1) ? 4 : 8;
      pad_exp = (dw - n % dw) % dw;
    end
  endfunction
  task chk(input [31:0] s, input [31:0] e);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("Error %0t: saw %h want %h", $time, s, e);
    end
  endtask
  task wr(input [11:0] a, input [31:0] v);
    hifrc_host_inst.xfer(1'b1, a, v, d);
    @(posedge clk); // Registered outputs of the write have settled here
  endtask
  task rd(input [11:0] a);
    hifrc_host_inst.xfer(1'b0, a, 32'h0, d);
  endtask
  task wrap_up;
    if (err_count == 0 && n_tests > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // A bus that never answers ends the run as a failure
  always @(posedge hung) begin
    err_count++;
    wrap_up;
  end
  hifrc_host hifrc_host_inst (.clk(clk), .pready(pready), .prdata(prdata), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .hung(hung));
  hifrc_regs hifrc_regs_inst (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(), .event_pulses(ev), .tx_data_free_blocks(txf), .tx_status_used_dwords(txs),
    .rx_data_free_blocks(rxf), .rx_status_used_dwords(rxs), .rx_dword_pop(pop),
    .rx_packet_end(pend), .host_irq(host_irq), .wake_pulse(wake), .rx_fifo_flush(flush),
    .rx_pad_dwords(pad), .rx_pad_valid(padv), .rx_start_byte_offset(offs),
    .rx_dword_countdown(cnt));
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(`HIFRC_OFF_INT_MASK);
    chk(d, 32'h0);
    rd(`HIFRC_OFF_FIFO_LVL);
    chk(d, 32'h48000000);
    // Random masks read back with reserved bits dropped
    for (i = 0; i < 4; i++) begin
      r = rnd();
      wr(`HIFRC_OFF_INT_MASK, r);
      rd(`HIFRC_OFF_INT_MASK);
      chk(d, r & 32'h83bfefff);
    end
    wr(`HIFRC_OFF_BYTE_ORDER, rnd());
    chk(wake, 1'b1);
    rd(`HIFRC_OFF_BYTE_ORDER);
    chk(d, 32'h87654321);
    rd(12'h080);
    chk(d, 32'h0);
    wr(`HIFRC_OFF_INT_MASK, 32'h0);
    // Sources 31, 25, 23, 15, 11 and 1 each latch while masked, then reach the output once enabled
    for (i = 0; i < 6; i++) begin
      ev <= 32'h1 << bl[i];
      @(posedge clk);
      ev <= 32'h0;
      rd(`HIFRC_OFF_STATUS);
      chk(d[bl[i]], 1'b1);
      chk(host_irq, 1'b0);
      wr(`HIFRC_OFF_INT_MASK, 32'h1 << bl[i]);
      chk(host_irq, 1'b1);
      wr(`HIFRC_OFF_STATUS, 32'h1 << bl[i]);
      chk(host_irq, 1'b0);
      wr(`HIFRC_OFF_INT_MASK, 32'h0);
    end
    // Levels just past each threshold (TX status by a random odd amount) and exactly at it
    wr(`HIFRC_OFF_FIFO_LVL, 32'h48001000);
    for (i = 0; i < 2; i++) begin
      r = rnd();
      txf <= i ? 8'h48 : 8'h49;
      txs <= i ? 8'h00 : (r[7:0] | 8'h01);
      rxf <= i ? 8'h10 : 8'h0f;
      rxs <= i ? 8'h00 : 8'h01;
      wr(`HIFRC_OFF_STATUS, 32'hffffffff);
      rd(`HIFRC_OFF_STATUS);
      chk(d & 32'h2a8, i ? 32'h0 : 32'h2a8);
    end
    wr(`HIFRC_OFF_RX_CFG, 32'h00050000);
    chk(cnt, 12'h005);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    @(posedge clk);
    chk(cnt, 12'h004);
    wr(`HIFRC_OFF_RX_CFG, 32'h00020000);
    chk(cnt, 12'h002);
    pop <= 1'b1;
    repeat (2) @(posedge clk);
    pop <= 1'b0;
    rd(`HIFRC_OFF_STATUS);
    chk(d[20], 1'b1);
    wr(`HIFRC_OFF_STATUS, 32'h00100000);
    rd(`HIFRC_OFF_STATUS);
    chk(d[20], 1'b0);
    // Whole-word offset waits for the next popped word
    wr(`HIFRC_OFF_RX_CFG, 32'h00001c00);
    chk(offs, 5'h00);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    @(posedge clk);
    chk(offs, 5'h1c);
    wr(`HIFRC_OFF_RX_CFG, 32'h00008000);
    chk(flush, 1'b1);
    rd(`HIFRC_OFF_RX_CFG);
    chk(d[15], 1'b0);
    // Flushed phase, then one packet of 1 to 8 DWORDs per end alignment
    for (i = 0; i < 3; i++) begin
      r = rnd();
      wr(`HIFRC_OFF_RX_CFG, i << 30);
      pop <= 1'b1;
      repeat (r[2:0]) @(posedge clk);
      pend <= 1'b1;
      @(posedge clk);
      pop <= 1'b0;
      pend <= 1'b0;
      @(posedge clk);
      chk(pad, pad_exp(i, r[2:0] + 1));
      chk(padv, 1'b1);
    end
    wrap_up;
  end
endmodule
